// file: include/qgi_pkg.sv
// Purpose: Shared constants and carrier types of the global interrupt block.
// Assumes: An 8-bit host bus, four serial channels, one system clock.
// Notes:   Register offsets are byte addresses on the host bus.

package qgi_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NCH = 4;
   localparam int CODE_W = 3;
   localparam int TCTRL_W = 4;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   localparam int ADDR_GLOBAL_BIT = 7;
   localparam int ADDR_CH_HI = 6;
   localparam int ADDR_CH_LO = 4;
   localparam int ADDR_REG_HI = 3;
   localparam logic [3:0] CH_ISR_OFS = 4'h2;
   localparam logic [3:0] CH_LSR_OFS = 4'h5;
   localparam logic [3:0] CH_MSR_OFS = 4'h6;

   localparam logic [7:0] ADDR_SUMMARY = 8'h80;
   localparam logic [7:0] ADDR_SRC_LOW = 8'h81;
   localparam logic [7:0] ADDR_SRC_HIGH = 8'h82;
   localparam logic [7:0] ADDR_SRC_SPARE = 8'h83;
   localparam logic [7:0] ADDR_TIMER_CTRL = 8'h84;
   localparam logic [7:0] ADDR_TIMER_PH = 8'h85;
   localparam logic [7:0] ADDR_TCOUNT_LO = 8'h86;
   localparam logic [7:0] ADDR_TCOUNT_HI = 8'h87;
   localparam logic [7:0] ADDR_OVERSAMPLE = 8'h88;
   localparam logic [7:0] ADDR_RSVD_A = 8'h89;
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h8a;
   localparam logic [7:0] ADDR_SLEEP = 8'h8b;
   localparam logic [7:0] ADDR_REVISION = 8'h8c;
   localparam logic [7:0] ADDR_DEVICE = 8'h8d;
   localparam logic [7:0] ADDR_BCAST = 8'h8e;

   // ---------------------------------------------------------------
   // Field positions and values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;
   localparam logic [CODE_W-1:0] CODE_RX = 3'h1;
   localparam logic [CODE_W-1:0] CODE_RX_TMO = 3'h2;
   localparam logic [CODE_W-1:0] CODE_TX = 3'h3;
   localparam logic [CODE_W-1:0] CODE_MODEM = 3'h4;
   localparam logic [CODE_W-1:0] CODE_TIMER = 3'h7;
   localparam int IER_RX = 0;
   localparam int IER_TX = 1;
   localparam int IER_LINE = 2;
   localparam int IER_MODEM = 3;
   localparam int IER_CHAR = 5;
   localparam int FEATURE_CONTROL_REG_HALF_DUPLEX = 5;
   localparam int TCTRL_IRQ_EN = 0;
   localparam int BCAST_BIT = 0;
   localparam logic [NCH-1:0] SLEEP_ALL = 4'hf;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [7:0] addr;
      logic [7:0] wdata;
   } qgi_pins_s;

   typedef struct packed {
      logic rx_ready;
      logic line_err_set;
      logic rx_tmo_set;
      logic rx_fifo_empty;
      logic thr_empty_set;
      logic tsr_empty_set;
      logic modem_delta_set;
      logic char_det_set;
      logic [7:0] irq_enable;
      logic [7:0] feature_ctrl;
   } qgi_chan_evt_s;

endpackage

// file: logic/qgi_global_irq.sv
// Purpose: Global interrupt aggregation and device register bank of a
//          four-channel serial controller.
// Assumes: Host bus pins are asynchronous; channel events arrive on
//          SYS_CLK as one-cycle set pulses and levels.
// Notes:   Address and data must be stable while a strobe is low.

`timescale 1ns/1ps

module qgi_global_irq
   import qgi_pkg::*;
#(
   // Arbitrary neutral identification values.
   parameter logic [7:0] REVISION_VALUE = 8'h01,
   parameter logic [7:0] DEVICE_VALUE = 8'h5a
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   input wire qgi_chan_evt_s [NCH-1:0] CHAN_EVT,
   input wire logic TIMER_TIMEOUT,
   input wire logic WAKE_EVENT,
   output logic IRQ,
   output logic [TCTRL_W-1:0] TIMER_CTRL,
   output logic [15:0] TIMER_COUNT,
   output logic [NCH-1:0] OVERSAMPLE_SEL,
   output logic [NCH-1:0] SOFT_RESET,
   output logic [NCH-1:0] SLEEP_EN,
   output logic BCAST_WRITE
);

   // ---------------------------------------------------------------
   // Host pin synchroniser
   // ---------------------------------------------------------------
   // The whole pin group moves through three stages together, so the
   // address and data seen at a strobe edge are as old as the strobe.
   qgi_pins_s pins_in;
   qgi_pins_s sync1_reg, sync2_reg, sync3_reg;
   logic rd_lvl_reg, rd_lvl_next;
   logic wr_lvl_reg, wr_lvl_next;
   logic rd_start, wr_start;
   logic strobe_stable;

   assign pins_in = '{cs_n: CS_N, rd_n: RD_N, wr_n: WR_N,
                      addr: ADDR, wdata: DATA_IN};

   always_comb begin
      strobe_stable = (sync2_reg.cs_n == sync3_reg.cs_n) &&
                      (sync2_reg.rd_n == sync3_reg.rd_n) &&
                      (sync2_reg.wr_n == sync3_reg.wr_n);
      rd_lvl_next = rd_lvl_reg;
      wr_lvl_next = wr_lvl_reg;
      if (strobe_stable) begin
         rd_lvl_next = ~sync3_reg.rd_n & ~sync3_reg.cs_n;
         wr_lvl_next = ~sync3_reg.wr_n & ~sync3_reg.cs_n;
      end
      rd_start = rd_lvl_next & ~rd_lvl_reg;
      wr_start = wr_lvl_next & ~wr_lvl_reg;
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         sync1_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                        addr: RST_BYTE, wdata: RST_BYTE};
         sync2_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                        addr: RST_BYTE, wdata: RST_BYTE};
         sync3_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                        addr: RST_BYTE, wdata: RST_BYTE};
         rd_lvl_reg <= 1'b0;
         wr_lvl_reg <= 1'b0;
      end else begin
         sync1_reg <= pins_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         rd_lvl_reg <= rd_lvl_next;
         wr_lvl_reg <= wr_lvl_next;
      end
   end

   // ---------------------------------------------------------------
   // Address decode of reads that clear causes
   // ---------------------------------------------------------------
   logic [7:0] bus_addr;
   logic [7:0] bus_wdata;
   logic global_hit;
   logic [NCH-1:0] isr_rd, lsr_rd, msr_rd;
   logic timer_ctrl_rd, summary_rd;

   always_comb begin
      bus_addr = sync3_reg.addr;
      bus_wdata = sync3_reg.wdata;
      global_hit = bus_addr[ADDR_GLOBAL_BIT];
      timer_ctrl_rd = rd_start && (bus_addr == ADDR_TIMER_CTRL);
      summary_rd = rd_start && (bus_addr == ADDR_SUMMARY);
      for (int i = 0; i < NCH; i++) begin
         logic chan_rd;
         chan_rd = 1'b0;
         chan_rd = rd_start && !global_hit &&
                   (bus_addr[ADDR_CH_HI:ADDR_CH_LO] == 3'(i));
         isr_rd[i] = chan_rd && (bus_addr[ADDR_REG_HI:0] == CH_ISR_OFS);
         lsr_rd[i] = chan_rd && (bus_addr[ADDR_REG_HI:0] == CH_LSR_OFS);
         msr_rd[i] = chan_rd && (bus_addr[ADDR_REG_HI:0] == CH_MSR_OFS);
      end
   end

   // ---------------------------------------------------------------
   // Control registers written by the host
   // ---------------------------------------------------------------
   logic [TCTRL_W-1:0] tctrl_reg, tctrl_next;
   logic [15:0] tcount_reg, tcount_next;
   logic [NCH-1:0] osel_reg, osel_next;
   logic [NCH-1:0] sreset_reg, sreset_next;
   logic [NCH-1:0] sleep_reg, sleep_next;
   logic bcast_reg, bcast_next;

   always_comb begin
      tctrl_next = tctrl_reg;
      tcount_next = tcount_reg;
      osel_next = osel_reg;
      sleep_next = sleep_reg;
      bcast_next = bcast_reg;
      // Soft reset bits clear themselves one cycle after the write.
      sreset_next = '0;
      if (wr_start) begin
         case (bus_addr)
            ADDR_TIMER_CTRL: tctrl_next = bus_wdata[TCTRL_W-1:0];
            ADDR_TCOUNT_LO: tcount_next[7:0] = bus_wdata;
            ADDR_TCOUNT_HI: tcount_next[15:8] = bus_wdata;
            ADDR_OVERSAMPLE: osel_next = bus_wdata[NCH-1:0];
            ADDR_SOFT_RESET: sreset_next = bus_wdata[NCH-1:0];
            ADDR_SLEEP: sleep_next = bus_wdata[NCH-1:0];
            ADDR_BCAST: bcast_next = bus_wdata[BCAST_BIT];
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tctrl_reg <= '0;
         tcount_reg <= '0;
         osel_reg <= '0;
         sreset_reg <= '0;
         sleep_reg <= '0;
         bcast_reg <= 1'b0;
      end else begin
         tctrl_reg <= tctrl_next;
         tcount_reg <= tcount_next;
         osel_reg <= osel_next;
         sreset_reg <= sreset_next;
         sleep_reg <= sleep_next;
         bcast_reg <= bcast_next;
      end
   end

   // ---------------------------------------------------------------
   // Sticky interrupt causes
   // ---------------------------------------------------------------
   // In every read-cleared cause a set in the same cycle as its clearing read wins,
   // so an event landing on the read is reported on the next one.
   logic [NCH-1:0] line_err_reg, line_err_next;
   logic [NCH-1:0] rx_tmo_reg, rx_tmo_next;
   logic [NCH-1:0] tx_rdy_reg, tx_rdy_next;
   logic [NCH-1:0] modem_reg, modem_next;
   logic [NCH-1:0] char_reg, char_next;
   logic timer_pend_reg, timer_pend_next;
   logic wake_reg, wake_next;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         logic tx_set;
         tx_set = 1'b0;
         tx_set = CHAN_EVT[i].feature_ctrl[FEATURE_CONTROL_REG_HALF_DUPLEX] ?
                  CHAN_EVT[i].tsr_empty_set :
                  CHAN_EVT[i].thr_empty_set;
         line_err_next[i] = CHAN_EVT[i].line_err_set |
                            (line_err_reg[i] & ~lsr_rd[i]);
         rx_tmo_next[i] = CHAN_EVT[i].rx_tmo_set |
            (rx_tmo_reg[i] & ~CHAN_EVT[i].rx_fifo_empty);
         tx_rdy_next[i] = tx_set | (tx_rdy_reg[i] & ~isr_rd[i]);
         modem_next[i] = CHAN_EVT[i].modem_delta_set |
                         (modem_reg[i] & ~msr_rd[i]);
         char_next[i] = CHAN_EVT[i].char_det_set |
                        (char_reg[i] & ~isr_rd[i]);
      end
      timer_pend_next = TIMER_TIMEOUT |
                        (timer_pend_reg & ~timer_ctrl_rd);
      // The wake interrupt only arms when every channel was asleep.
      wake_next = (WAKE_EVENT && (sleep_reg == SLEEP_ALL)) |
                  (wake_reg & ~summary_rd);
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         line_err_reg <= '0;
         rx_tmo_reg <= '0;
         tx_rdy_reg <= '0;
         modem_reg <= '0;
         char_reg <= '0;
         timer_pend_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         line_err_reg <= line_err_next;
         rx_tmo_reg <= rx_tmo_next;
         tx_rdy_reg <= tx_rdy_next;
         modem_reg <= modem_next;
         char_reg <= char_next;
         timer_pend_reg <= timer_pend_next;
         wake_reg <= wake_next;
      end
   end

   // ---------------------------------------------------------------
   // Priority encode and global registers
   // ---------------------------------------------------------------
   logic [NCH-1:0][CODE_W-1:0] code;
   logic timer_irq;
   logic [NCH-1:0] summary_reg, summary_next;
   logic [7:0] src_low_reg, src_low_next;
   logic [7:0] src_high_reg, src_high_next;
   logic irq_reg, irq_next;

   always_comb begin
      timer_irq = timer_pend_reg & tctrl_reg[TCTRL_IRQ_EN];
      for (int i = 0; i < NCH; i++) begin
         logic [7:0] en;
         en = CHAN_EVT[i].irq_enable;
         code[i] = CODE_NONE;
         if ((CHAN_EVT[i].rx_ready & en[IER_RX]) |
             (line_err_reg[i] & en[IER_LINE])) begin
            code[i] = CODE_RX;
         end else if (rx_tmo_reg[i] & en[IER_RX]) begin
            code[i] = CODE_RX_TMO;
         end else if (tx_rdy_reg[i] & en[IER_TX]) begin
            code[i] = CODE_TX;
         end else if ((modem_reg[i] & en[IER_MODEM]) |
                      (char_reg[i] & en[IER_CHAR])) begin
            code[i] = CODE_MODEM;
         end else if ((i == 0) && timer_irq) begin
            code[i] = CODE_TIMER;
         end
         summary_next[i] = (code[i] != CODE_NONE);
      end
      src_low_next = {code[2][1:0], code[1], code[0]};
      src_high_next = {4'h0, code[3], code[2][2]};
      irq_next = (|summary_next) | timer_irq | wake_reg;
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         summary_reg <= '0;
         src_low_reg <= RST_BYTE;
         src_high_reg <= RST_BYTE;
         irq_reg <= 1'b0;
      end else begin
         summary_reg <= summary_next;
         src_low_reg <= src_low_next;
         src_high_reg <= src_high_next;
         irq_reg <= irq_next;
      end
   end

   // ---------------------------------------------------------------
   // Read data path
   // ---------------------------------------------------------------
   // Data is captured at the start of the read, the same cycle that
   // clears the read-sensitive causes, so the host sees the old state.
   logic [7:0] rdata_reg, rdata_next;
   logic oe_reg, oe_next;

   always_comb begin
      rdata_next = rdata_reg;
      oe_next = rd_lvl_next & global_hit;
      if (rd_start && global_hit) begin
         case (bus_addr)
            ADDR_SUMMARY: rdata_next = {4'h0, summary_reg};
            ADDR_SRC_LOW: rdata_next = src_low_reg;
            ADDR_SRC_HIGH: rdata_next = src_high_reg;
            ADDR_SRC_SPARE: rdata_next = RST_BYTE;
            ADDR_TIMER_CTRL: rdata_next = {4'h0, tctrl_reg};
            ADDR_TCOUNT_LO: rdata_next = tcount_reg[7:0];
            ADDR_TCOUNT_HI: rdata_next = tcount_reg[15:8];
            ADDR_OVERSAMPLE: rdata_next = {4'h0, osel_reg};
            ADDR_SLEEP: rdata_next = {4'h0, sleep_reg};
            ADDR_REVISION: rdata_next = REVISION_VALUE;
            ADDR_DEVICE: rdata_next = DEVICE_VALUE;
            ADDR_BCAST: rdata_next = {7'h00, bcast_reg};
            default: rdata_next = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_reg <= RST_BYTE;
         oe_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         oe_reg <= oe_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign DATA_OUT = rdata_reg;
   assign DATA_OE = oe_reg;
   assign IRQ = irq_reg;
   assign TIMER_CTRL = tctrl_reg;
   assign TIMER_COUNT = tcount_reg;
   assign OVERSAMPLE_SEL = osel_reg;
   assign SOFT_RESET = sreset_reg;
   assign SLEEP_EN = sleep_reg;
   assign BCAST_WRITE = bcast_reg;

endmodule

// file: tb/qgi_global_irq_assertions.sv
// Purpose: Port-level checks of the global interrupt block.
// Assumes: The host holds ADDR stable while a strobe is low.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ps
module qgi_global_irq_assertions
   import qgi_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] DATA_OUT,
   input wire logic DATA_OE,
   input wire qgi_chan_evt_s [NCH-1:0] CHAN_EVT,
   input wire logic TIMER_TIMEOUT,
   input wire logic IRQ,
   input wire logic [TCTRL_W-1:0] TIMER_CTRL
);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   AST_RST_QUIET: assert property (
      $rose(RSTN) |-> !IRQ && DATA_OUT == 8'h00)
      else $error("Outputs not clear after reset.");
   AST_SUM_HI_ZERO: assert property (
      $rose(DATA_OE) && ADDR == ADDR_SUMMARY |-> DATA_OUT[7:4] == 4'h0)
      else $error("Summary upper bits not zero.");
   AST_SPARE_ZERO: assert property (
      $rose(DATA_OE) && ADDR == ADDR_SRC_SPARE |-> DATA_OUT == 8'h00)
      else $error("Spare source register not zero.");
   AST_SRC_LOW_CODES: assert property (
      $rose(DATA_OE) && ADDR == ADDR_SRC_LOW |->
      !(DATA_OUT[2:0] inside {3'h5, 3'h6}) &&
      !(DATA_OUT[5:3] inside {3'h5, 3'h6, 3'h7}))
      else $error("Reserved code in low source register.");
   AST_SRC_HIGH_CODES: assert property (
      $rose(DATA_OE) && ADDR == ADDR_SRC_HIGH |->
      DATA_OUT[7:4] == 4'h0 && DATA_OUT[3:1] != 3'h7)
      else $error("Bad field in high source register.");
   AST_LINE_IRQ: assert property (
      CHAN_EVT[0].line_err_set && CHAN_EVT[0].irq_enable[IER_LINE]
      |-> ##2 IRQ)
      else $error("Line error did not raise the interrupt.");
   AST_MODEM_IRQ: assert property (
      CHAN_EVT[2].modem_delta_set && CHAN_EVT[2].irq_enable[IER_MODEM]
      |-> ##2 IRQ)
      else $error("Modem delta did not raise the interrupt.");
   AST_HALF_DUPLEX_IRQ: assert property (
      CHAN_EVT[1].tsr_empty_set && CHAN_EVT[1].irq_enable[IER_TX] &&
      CHAN_EVT[1].feature_ctrl[FEATURE_CONTROL_REG_HALF_DUPLEX] |-> ##2 IRQ)
      else $error("Shift empty did not raise the interrupt.");
   AST_TIMER_IRQ: assert property (
      TIMER_TIMEOUT && TIMER_CTRL[TCTRL_IRQ_EN] |-> ##[1:3] IRQ)
      else $error("Enabled timer time-out gave no interrupt.");
endmodule

bind qgi_global_irq qgi_global_irq_assertions u_chk (
   .SYS_CLK(SYS_CLK),
   .RSTN(RSTN),
   .ADDR(ADDR),
   .DATA_OUT(DATA_OUT),
   .DATA_OE(DATA_OE),
   .CHAN_EVT(CHAN_EVT),
   .TIMER_TIMEOUT(TIMER_TIMEOUT),
   .IRQ(IRQ),
   .TIMER_CTRL(TIMER_CTRL)
);

// file: tb/qgi_global_irq_tb.sv
// Purpose: Self-checking bench of the global interrupt block.
// Assumes: Event bit positions follow the packed channel struct.
// Notes:   Channel reads only clear causes; their data is ignored.
`timescale 1ns/1ps
module qgi_global_irq_tb
   import qgi_pkg::*;
;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   localparam logic [7:0] REV_V = 8'h03; // Arbitrary value.
   localparam logic [7:0] DEV_V = 8'h6b; // Arbitrary value.
   localparam int P_LINE = 22, P_TMO = 21, P_THR = 19, P_TSR = 18;
   localparam int P_MODEM = 17, P_CHAR = 16;
   logic sys_clk, rstn, cs_n, rd_n, wr_n, oe, irq, bcast;
   logic [7:0] addr, din, dout;
   logic [1:0] gev;
   logic [3:0] tctrl, ovs, srst, slp, sr_seen;
   logic [15:0] tcnt;
   qgi_chan_evt_s [NCH-1:0] evt;
   int num_errors = 0;
   int n_compared = 0;
   qgi_global_irq #(.REVISION_VALUE(REV_V), .DEVICE_VALUE(DEV_V)) dut (
      .SYS_CLK(sys_clk), .RSTN(rstn), .CS_N(cs_n), .RD_N(rd_n),
      .WR_N(wr_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout),
      .DATA_OE(oe), .CHAN_EVT(evt), .TIMER_TIMEOUT(gev[0]),
      .WAKE_EVENT(gev[1]), .IRQ(irq), .TIMER_CTRL(tctrl),
      .TIMER_COUNT(tcnt), .OVERSAMPLE_SEL(ovs), .SOFT_RESET(srst),
      .SLEEP_EN(slp), .BCAST_WRITE(bcast));
   qgi_host_model host (.clk(sys_clk), .data_out(dout), .data_oe(oe),
      .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(din));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Soft-reset bits are one-cycle pulses, so collect them.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) sr_seen <= 4'h0;
      else sr_seen <= sr_seen | srst;
   end
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Global reads drive the data bus; channel reads and writes never do.
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic o;
      host.access(1'b0, a, 8'h00, d, o);
      chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
      chk("oe", 16'h1, {15'h0, o});
   endtask
   task automatic crd(input logic [7:0] a);
      logic [7:0] d;
      logic o;
      host.access(1'b0, a, 8'h00, d, o);
      chk("oe", 16'h0, {15'h0, o});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] d;
      logic o;
      host.access(1'b1, a, v, d, o);
      chk("oe", 16'h0, {15'h0, o});
   endtask
   // Channel NCH stands for the timer and wake pulses.
   task automatic pulse(input int c, input int p);
      @(posedge sys_clk);
      #1;
      if (c == NCH) gev[p] = 1'b1;
      else evt[c][p] = 1'b1;
      @(posedge sys_clk);
      #1;
      if (c == NCH) gev[p] = 1'b0;
      else evt[c][p] = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      chk("irq", 16'h0, {15'h0, irq});
      for (int i = 0; i < 4; i++) rc(ADDR_SUMMARY + 8'(i), 8'h00);
      wr(ADDR_TIMER_CTRL, 8'hfe);
      chk("tctrl", 16'he, {12'h0, tctrl});
      rc(ADDR_TIMER_CTRL, 8'h0e);
      wr(ADDR_TCOUNT_LO, 8'h34);
      wr(ADDR_TCOUNT_HI, 8'h12);
      chk("tcount", 16'h1234, tcnt);
      rc(ADDR_TCOUNT_HI, 8'h12);
      wr(ADDR_OVERSAMPLE, 8'h0a);
      wr(ADDR_BCAST, 8'h01);
      wr(ADDR_SOFT_RESET, 8'h05);
      chk("ctl", 16'ha150, {ovs, 3'h0, bcast, sr_seen, srst});
      rc(ADDR_OVERSAMPLE, 8'h0a);
      wr(ADDR_SRC_SPARE, 8'hff);
      rc(ADDR_SRC_SPARE, 8'h00);
      rc(ADDR_TIMER_PH, 8'h00);
      rc(ADDR_RSVD_A, 8'h00);
      rc(ADDR_SOFT_RESET, 8'h00);
      rc(ADDR_REVISION, REV_V);
      rc(ADDR_DEVICE, DEV_V);
      rc(8'h8f, 8'h00);
      wr(ADDR_BCAST, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_line();
      evt[0].irq_enable = 8'h04;
      pulse(0, P_LINE);
      chk("irq", 16'h1, {15'h0, irq});
      rc(ADDR_SUMMARY, 8'h01);
      rc(ADDR_SRC_LOW, 8'h01);
      crd(8'h05);
      rc(ADDR_SUMMARY, 8'h00);
      rc(ADDR_SRC_LOW, 8'h00);
      chk("irq", 16'h0, {15'h0, irq});
      $display("t_line done");
   endtask
   task automatic t_prio();
      evt[2].irq_enable = 8'h2f;
      pulse(2, P_MODEM);
      pulse(2, P_THR);
      pulse(2, P_TMO);
      rc(ADDR_SRC_LOW, 8'h80);
      rc(ADDR_SRC_HIGH, 8'h00);
      evt[2].rx_fifo_empty = 1'b1;
      rc(ADDR_SRC_LOW, 8'hc0);
      rc(ADDR_SUMMARY, 8'h04);
      crd(8'h22);
      rc(ADDR_SRC_LOW, 8'h00);
      rc(ADDR_SRC_HIGH, 8'h01);
      crd(8'h26);
      rc(ADDR_SRC_HIGH, 8'h00);
      $display("t_prio done");
   endtask
   task automatic t_mask();
      pulse(1, P_LINE);
      chk("irq", 16'h0, {15'h0, irq});
      rc(ADDR_SUMMARY, 8'h00);
      crd(8'h15);
      evt[3].irq_enable = 8'h21;
      pulse(3, P_CHAR);
      evt[3].rx_ready = 1'b1;
      rc(ADDR_SRC_HIGH, 8'h02);
      evt[3].rx_ready = 1'b0;
      rc(ADDR_SRC_HIGH, 8'h08);
      crd(8'h32);
      rc(ADDR_SRC_HIGH, 8'h00);
      $display("t_mask done");
   endtask
   task automatic t_half();
      evt[1].irq_enable = 8'h02;
      evt[1].feature_ctrl = 8'h20;
      pulse(1, P_THR);
      rc(ADDR_SUMMARY, 8'h00);
      pulse(1, P_TSR);
      rc(ADDR_SRC_LOW, 8'h18);
      crd(8'h12);
      rc(ADDR_SRC_LOW, 8'h00);
      $display("t_half done");
   endtask
   task automatic t_timer();
      wr(ADDR_TIMER_CTRL, 8'h00);
      pulse(NCH, 0);
      chk("irq", 16'h0, {15'h0, irq});
      rc(ADDR_TIMER_CTRL, 8'h00);
      wr(ADDR_TIMER_CTRL, 8'h01);
      pulse(NCH, 0);
      chk("irq", 16'h1, {15'h0, irq});
      rc(ADDR_SRC_LOW, 8'h07);
      rc(ADDR_SUMMARY, 8'h01);
      rc(ADDR_TIMER_CTRL, 8'h01);
      rc(ADDR_SRC_LOW, 8'h00);
      $display("t_timer done");
   endtask
   task automatic t_wake();
      wr(ADDR_SLEEP, 8'h07);
      pulse(NCH, 1);
      chk("irq", 16'h0, {15'h0, irq});
      rc(ADDR_SUMMARY, 8'h00);
      wr(ADDR_SLEEP, 8'h0f);
      chk("sleep", 16'hf, {12'h0, slp});
      pulse(NCH, 1);
      chk("irq", 16'h1, {15'h0, irq});
      rc(ADDR_SUMMARY, 8'h00);
      chk("irq", 16'h0, {15'h0, irq});
      wr(ADDR_SLEEP, 8'h00);
      $display("t_wake done");
   endtask
   task automatic t_rerst();
      pulse(0, P_LINE);
      rstn = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      chk("irq", 16'h0, {15'h0, irq});
      rc(ADDR_SUMMARY, 8'h00);
      $display("t_rerst done");
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      gev = 2'h0;
      evt = '0;
      repeat (6) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      t_regs();
      t_line();
      t_prio();
      t_mask();
      t_half();
      t_timer();
      t_wake();
      t_rerst();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      conclude();
   end
endmodule

// file: tb/qgi_host_model.sv
// Purpose: Host processor on the 8-bit strobe bus.
// Assumes: Strobes are held long enough for the three-flop sync.
// Notes:   Released data lines show the inverse of the last value.
`timescale 1ns/1ps
module qgi_host_model (
   input wire logic clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] addr,
   output logic [7:0] data_in
);
   // ------------------------------------------------------------
   // Bus cycle
   // ------------------------------------------------------------
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 8'h00;
      data_in = 8'h00;
   end
   // Eight low cycles cover the sync delay plus the answer cycle.
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [7:0] wd, output logic [7:0] rv,
                         output logic ov);
      @(posedge clk);
      #1;
      addr = a;
      data_in = wr ? wd : ~data_in;
      cs_n = 1'b0;
      rd_n = wr;
      wr_n = !wr;
      repeat (8) @(posedge clk);
      rv = data_out;
      ov = data_oe;
      #1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data_in = ~data_in;
      repeat (6) @(posedge clk);
      #1;
   endtask
endmodule
